// >>> verilog/ffc_consts.vh
// constants for the frame filter control register bank
`ifndef FFC_CONSTS_VH
`define FFC_CONSTS_VH

// ****************************************
// register offsets
// ****************************************
`define FFC_ADDR_W 8
`define FFC_DATA_W 8
`define FFC_OFS_FILT_FIRST 8'h00
`define FFC_OFS_FILT_SECOND 8'h01
`define FFC_OFS_SRC_MATCH 8'h02
`define FFC_OFS_EVENT_FLAGS 8'h03
`define FFC_OFS_REQUEST 8'h04
`define FFC_OFS_REJECT_COUNT 8'h05
`define FFC_OFS_GAIN_CTRL 8'h06

// ****************************************
// reset values
// ****************************************
`define FFC_RST_FILT_FIRST 8'h0d
`define FFC_RST_FILT_SECOND 8'h78
`define FFC_RST_SRC_MATCH 8'h07
`define FFC_RST_GAIN_CTRL 8'h00

// ****************************************
// field positions
// ****************************************
`define FFC_BIT_FILTER_EN 0
`define FFC_BIT_COORD_ROLE 1
`define FFC_MAXVER_LSB 2
`define FFC_MAXVER_MSB 3
`define FFC_RESMASK_LSB 4
`define FFC_RESMASK_MSB 6
`define FFC_FCW_RES_LSB 7
`define FFC_FCW_RES_MSB 9
`define FFC_FCW_VER_LSB 12
`define FFC_FCW_VER_MSB 13
`define FFC_EVT_REJECT 0
`define FFC_EVT_ACCEPT 1
`define FFC_REQ_CLR_COUNT 0
`define FFC_REQ_CLR_FLAGS 1
`define FFC_GAIN_OVR_BIT 7
`define FFC_GAIN_W 7
`define FFC_NUM_EVT 2
`define FFC_COUNT_MAX 8'hff
`define FFC_NUM_REQ 2
`define FFC_SECOND_EFF_MSB 7
`define FFC_SECOND_EFF_LSB 1
`define FFC_SRC_EFF_MSB 2
`define FFC_SRC_EFF_LSB 0
`define FFC_GAIN_MAN_MSB 6
`define FFC_GAIN_MAN_LSB 0

`endif

// >>> verilog/ffc_regs.v
// frame filter control register bank with filter decision logic
`include "ffc_consts.vh"

module ffc_regs (
	input wire i_sys_clk,
	input wire i_reset_n,
	input wire [7:0] i_addr,
	input wire [7:0] i_wr_data,
	input wire i_wr_en,
	input wire i_rd_en,
	output wire [7:0] o_rd_data,
	input wire i_frame_valid,
	input wire [15:0] i_frame_control_word,
	input wire i_has_dst_addr,
	input wire [6:0] i_gain_auto,
	output wire o_decision_valid,
	output wire o_frame_reject,
	output wire o_filter_en,
	output wire o_coordinator_role,
	output wire [6:0] o_filt_second_eff,
	output wire [2:0] o_src_match_eff,
	output wire [6:0] o_gain_value
);

	// ****************************************
	// reset release
	// ****************************************
	reg rst_meta_ff;
	reg rst_sync_ff;

	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	wire rst_n = rst_sync_ff;

	// ****************************************
	// address decode
	// ****************************************
	function hit;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			hit = (addr == ofs);
		end
	endfunction

	wire wr_first = i_wr_en && hit(i_addr, `FFC_OFS_FILT_FIRST);
	wire wr_second = i_wr_en && hit(i_addr, `FFC_OFS_FILT_SECOND);
	wire wr_src = i_wr_en && hit(i_addr, `FFC_OFS_SRC_MATCH);
	wire wr_flags = i_wr_en && hit(i_addr, `FFC_OFS_EVENT_FLAGS);
	wire wr_req = i_wr_en && hit(i_addr, `FFC_OFS_REQUEST);
	wire wr_gain = i_wr_en && hit(i_addr, `FFC_OFS_GAIN_CTRL);

	// ****************************************
	// plain configuration registers
	// ****************************************
	// map, one byte each:
	// 0x00 first filter config, read/write
	// 0x01 second filter config, read/write
	// 0x02 source match control, read/write
	// 0x03 event flags, write_zero_only, set by hardware
	// 0x04 requests, write_one_only, cleared by hardware next cycle
	// 0x05 reject count, read only, saturating
	// 0x06 gain control, effective-value readback
	// anything else reads zero and ignores writes
	reg [7:0] filt_first_ff;
	reg [7:0] filt_second_ff;
	reg [7:0] src_match_ff;
	reg [7:0] gain_ctrl_ff;

	// unused bits are kept as written; software is expected to leave them zero
	always @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			filt_first_ff <= `FFC_RST_FILT_FIRST;
			filt_second_ff <= `FFC_RST_FILT_SECOND;
			src_match_ff <= `FFC_RST_SRC_MATCH;
			gain_ctrl_ff <= `FFC_RST_GAIN_CTRL;
		end else begin
			if (wr_first) begin
				filt_first_ff <= i_wr_data;
			end
			if (wr_second) begin
				filt_second_ff <= i_wr_data;
			end
			if (wr_src) begin
				src_match_ff <= i_wr_data;
			end
			if (wr_gain) begin
				gain_ctrl_ff <= i_wr_data;
			end
		end
	end

	// ****************************************
	// configuration seen by the filter
	// ****************************************
	wire filter_en = filt_first_ff[`FFC_BIT_FILTER_EN];
	wire coord_role = filt_first_ff[`FFC_BIT_COORD_ROLE];
	wire [1:0] max_ver = filt_first_ff[`FFC_MAXVER_MSB:`FFC_MAXVER_LSB];
	wire [2:0] res_mask = filt_first_ff[`FFC_RESMASK_MSB:`FFC_RESMASK_LSB];

	reg coord_eff;
	reg [6:0] second_eff;
	reg [2:0] src_eff;

	// gate dependent bits
	// forcing zeros keeps stale settings from leaking into the datapath while off
	always @* begin
		coord_eff = 1'b0;
		second_eff = 7'h00;
		src_eff = 3'h0;
		if (filter_en) begin
			coord_eff = coord_role;
			second_eff = filt_second_ff[`FFC_SECOND_EFF_MSB:`FFC_SECOND_EFF_LSB];
			src_eff = src_match_ff[`FFC_SRC_EFF_MSB:`FFC_SRC_EFF_LSB];
		end
	end

	assign o_filter_en = filter_en;
	assign o_coordinator_role = coord_eff;
	assign o_filt_second_eff = second_eff;
	assign o_src_match_eff = src_eff;

	// ****************************************
	// effective gain selector
	// ****************************************
	// the consumer always sees this mux, so readback uses it too
	wire gain_ovr = gain_ctrl_ff[`FFC_GAIN_OVR_BIT];
	reg [6:0] gain_eff;

	always @* begin
		if (gain_ovr) begin
			gain_eff = gain_ctrl_ff[`FFC_GAIN_MAN_MSB:`FFC_GAIN_MAN_LSB];
		end else begin
			gain_eff = i_gain_auto;
		end
	end

	assign o_gain_value = gain_eff;

	// ****************************************
	// filter decision
	// ****************************************
	wire [2:0] fcw_res = i_frame_control_word[`FFC_FCW_RES_MSB:`FFC_FCW_RES_LSB];
	wire [1:0] fcw_ver = i_frame_control_word[`FFC_FCW_VER_MSB:`FFC_FCW_VER_LSB];

	wire rej_res = |(res_mask & fcw_res);
	wire rej_ver = (fcw_ver > max_ver);
	wire rej_dst = !i_has_dst_addr && !coord_role;
	wire reject_now = filter_en && (rej_res || rej_ver || rej_dst);

	reg decision_valid_ff;
	reg frame_reject_ff;

	// decision is registered so the datapath gets a clean one-cycle strobe
	always @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			decision_valid_ff <= 1'b0;
			frame_reject_ff <= 1'b0;
		end else begin
			decision_valid_ff <= i_frame_valid;
			if (i_frame_valid) begin
				frame_reject_ff <= reject_now;
			end
		end
	end

	assign o_decision_valid = decision_valid_ff;
	assign o_frame_reject = frame_reject_ff;

	// ****************************************
	// request bits, write one only
	// ****************************************
	reg [1:0] req_ff;
	wire [1:0] req_done;

	// a request lives one cycle, so its own action is the acknowledge
	assign req_done = req_ff;

	genvar gr;
	generate
		for (gr = 0; gr < `FFC_NUM_REQ; gr = gr + 1) begin : g_req
			reg nxt_req;

			always @* begin
				nxt_req = req_ff[gr];
				if (req_done[gr]) begin
					nxt_req = 1'b0;
				end
				if (wr_req && i_wr_data[gr]) begin
					nxt_req = 1'b1;
				end
			end

			always @(posedge i_sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					req_ff[gr] <= 1'b0;
				end else begin
					req_ff[gr] <= nxt_req;
				end
			end
		end
	endgenerate

	// ****************************************
	// event flags, write zero only
	// ****************************************
	reg [1:0] flags_ff;
	wire [1:0] evt_set;

	assign evt_set[`FFC_EVT_REJECT] = decision_valid_ff && frame_reject_ff;
	assign evt_set[`FFC_EVT_ACCEPT] = decision_valid_ff && !frame_reject_ff;

	genvar gf;
	generate
		for (gf = 0; gf < `FFC_NUM_EVT; gf = gf + 1) begin : g_flag
			reg nxt_flag;

			always @* begin
				nxt_flag = flags_ff[gf];
				if (wr_flags && !i_wr_data[gf]) begin
					nxt_flag = 1'b0;
				end
				if (req_ff[`FFC_REQ_CLR_FLAGS]) begin
					nxt_flag = 1'b0;
				end
				// a new event beats any clear in the same cycle
				if (evt_set[gf]) begin
					nxt_flag = 1'b1;
				end
			end

			always @(posedge i_sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					flags_ff[gf] <= 1'b0;
				end else begin
					flags_ff[gf] <= nxt_flag;
				end
			end
		end
	endgenerate

	// ****************************************
	// reject counter
	// ****************************************
	reg [7:0] reject_count_ff;
	reg [7:0] nxt_reject_count;
	wire count_full = (reject_count_ff == `FFC_COUNT_MAX);

	// saturates rather than wraps so a busy channel never reads as quiet
	always @* begin
		nxt_reject_count = reject_count_ff;
		if (req_ff[`FFC_REQ_CLR_COUNT]) begin
			nxt_reject_count = 8'h00;
		end else if (evt_set[`FFC_EVT_REJECT] && !count_full) begin
			nxt_reject_count = reject_count_ff + 8'h01;
		end
	end

	always @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reject_count_ff <= 8'h00;
		end else begin
			reject_count_ff <= nxt_reject_count;
		end
	end

	// ****************************************
	// read port
	// ****************************************
	reg [7:0] rd_data_ff;
	reg [7:0] nxt_rd_data;

	always @* begin
		nxt_rd_data = 8'h00;
		if (i_rd_en) begin
			case (i_addr)
				`FFC_OFS_FILT_FIRST: begin
					nxt_rd_data = filt_first_ff;
				end
				`FFC_OFS_FILT_SECOND: begin
					nxt_rd_data = filt_second_ff;
				end
				`FFC_OFS_SRC_MATCH: begin
					nxt_rd_data = src_match_ff;
				end
				`FFC_OFS_EVENT_FLAGS: begin
					nxt_rd_data = {6'h00, flags_ff};
				end
				`FFC_OFS_REQUEST: begin
					nxt_rd_data = {6'h00, req_ff};
				end
				`FFC_OFS_REJECT_COUNT: begin
					nxt_rd_data = reject_count_ff;
				end
				`FFC_OFS_GAIN_CTRL: begin
					nxt_rd_data = {gain_ovr, gain_eff};
				end
				default: begin
					nxt_rd_data = 8'h00;
				end
			endcase
		end
	end

	always @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_ff <= 8'h00;
		end else begin
			rd_data_ff <= nxt_rd_data;
		end
	end

	assign o_rd_data = rd_data_ff;

endmodule

// >>> testbench/ffc_regs_sva.sv
// port assertions for the frame filter register bank
module ffc_regs_sva (
	input wire i_sys_clk,
	input wire i_reset_n,
	input wire [7:0] i_addr,
	input wire i_rd_en,
	input wire [7:0] o_rd_data,
	input wire i_frame_valid,
	input wire i_has_dst_addr,
	input wire o_decision_valid,
	input wire o_frame_reject,
	input wire o_filter_en,
	input wire o_coordinator_role,
	input wire [6:0] o_filt_second_eff,
	input wire [2:0] o_src_match_eff,
	input wire [6:0] o_gain_value
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	AST_DEC_ONE: assert property (i_frame_valid |=> o_decision_valid)
		else $error("decision missing after frame");
	AST_DEC_NONE: assert property (!i_frame_valid |=> !o_decision_valid)
		else $error("decision without frame");
	AST_REJ_HOLD: assert property (!o_decision_valid |-> $stable(o_frame_reject))
		else $error("reject moved without decision");
	AST_OFF_PASS: assert property (i_frame_valid && !o_filter_en |=> !o_frame_reject)
		else $error("reject while filtering off");
	AST_NO_DST: assert property (i_frame_valid && o_filter_en && !i_has_dst_addr
		&& !o_coordinator_role |=> o_frame_reject) else $error("no-destination frame passed");
	AST_OFF_EFF: assert property (!o_filter_en |-> o_filt_second_eff == 7'h00
		&& o_src_match_eff == 3'h0 && !o_coordinator_role) else $error("fields live while off");
	AST_GAIN_RB: assert property (i_rd_en && i_addr == 8'h06
		|=> o_rd_data[6:0] == $past(o_gain_value)) else $error("gain readback not effective");
	AST_EN_RB: assert property (i_rd_en && i_addr == 8'h00
		|=> o_rd_data[0] == $past(o_filter_en)) else $error("enable readback wrong");
	AST_RD_IDLE: assert property (!i_rd_en |=> o_rd_data == 8'h00)
		else $error("read data outside read cycle");
endmodule
bind ffc_regs ffc_regs_sva u_sva (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
	.i_addr(i_addr), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
	.i_frame_valid(i_frame_valid), .i_has_dst_addr(i_has_dst_addr),
	.o_decision_valid(o_decision_valid), .o_frame_reject(o_frame_reject),
	.o_filter_en(o_filter_en), .o_coordinator_role(o_coordinator_role),
	.o_filt_second_eff(o_filt_second_eff), .o_src_match_eff(o_src_match_eff),
	.o_gain_value(o_gain_value));

// >>> testbench/ffc_regs_tb.sv
// self-checking bench for the frame filter register bank
module ffc_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_sys_clk = 1'b0, i_reset_n = 1'b0, i_wr_en = 1'b0, i_rd_en = 1'b0;
	logic i_frame_valid = 1'b0, i_has_dst_addr = 1'b1;
	logic [7:0] i_addr = 8'h00, i_wr_data = 8'h00, o_rd_data;
	logic [15:0] i_frame_control_word = 16'h0000;
	logic [6:0] i_gain_auto = 7'h2a, o_filt_second_eff, o_gain_value;
	logic [2:0] o_src_match_eff;
	logic o_decision_valid, o_frame_reject, o_filter_en, o_coordinator_role;
	wire [15:0] eff_view = {4'h0, o_filter_en, o_coordinator_role, o_filt_second_eff, o_src_match_eff};
	int n_mismatch = 0, n_compared = 0, n_cycles = 0;
	ffc_regs DUT (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
		.i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
		.i_frame_valid(i_frame_valid), .i_frame_control_word(i_frame_control_word),
		.i_has_dst_addr(i_has_dst_addr), .i_gain_auto(i_gain_auto),
		.o_decision_valid(o_decision_valid), .o_frame_reject(o_frame_reject),
		.o_filter_en(o_filter_en), .o_coordinator_role(o_coordinator_role),
		.o_filt_second_eff(o_filt_second_eff), .o_src_match_eff(o_src_match_eff),
		.o_gain_value(o_gain_value));
	always #25 i_sys_clk = ~i_sys_clk;
	// the whole sequence needs well under 300 cycles
	always @(posedge i_sys_clk) begin
		n_cycles++;
		if (n_cycles == 3000) begin
			n_mismatch++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_wr_en <= 1'b1;
		i_addr <= a;
		i_wr_data <= d;
		@(posedge i_sys_clk);
		i_wr_en <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_sys_clk);
		i_rd_en <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd_en <= 1'b0;
		#1 chk("rd_data", {8'h00, exp}, {8'h00, o_rd_data});
	endtask
	// write, then read the same address at the very next edge
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
		@(posedge i_sys_clk);
		i_wr_en <= 1'b1;
		i_addr <= a;
		i_wr_data <= d;
		@(posedge i_sys_clk);
		i_wr_en <= 1'b0;
		i_rd_en <= 1'b1;
		@(posedge i_sys_clk);
		i_rd_en <= 1'b0;
		#1 chk("rd_data", {8'h00, exp}, {8'h00, o_rd_data});
	endtask
	task automatic frm(input logic [15:0] fcw, input logic dst, input logic exp);
		@(posedge i_sys_clk);
		i_frame_valid <= 1'b1;
		i_frame_control_word <= fcw;
		i_has_dst_addr <= dst;
		@(posedge i_sys_clk);
		i_frame_valid <= 1'b0;
		#1 chk("reject", {15'h0, exp}, {15'h0, o_frame_reject});
		chk("decision_valid", 16'h1, {15'h0, o_decision_valid});
	endtask
	initial begin
		repeat (2) @(posedge i_sys_clk);
		i_reset_n <= 1'b1;
		repeat (3) @(posedge i_sys_clk);
		rd(8'h00, 8'h0d);
		rd(8'h01, 8'h78);
		rd(8'h02, 8'h07);
		rd(8'h07, 8'h00);
		wr(8'h00, 8'h00);
		rd(8'h00, 8'h00);
		chk("eff", 16'h0000, eff_view);
		frm(16'h3380, 1'b0, 1'b0);
		wr(8'h00, 8'h05);
		for (int v = 0; v < 4; v++) frm(16'(v) << 12, 1'b1, v > 1);
		wr(8'h00, 8'h2d);
		frm(16'h0100, 1'b1, 1'b1);
		frm(16'h0280, 1'b1, 1'b0);
		frm(16'h0000, 1'b0, 1'b1);
		wr(8'h00, 8'h0f);
		frm(16'h0000, 1'b0, 1'b0);
		rd(8'h00, 8'h0f);
		wr(8'h01, 8'ha4);
		rd(8'h01, 8'ha4);
		wr(8'h02, 8'h05);
		rd(8'h02, 8'h05);
		chk("eff", 16'h0e95, eff_view);
		rd(8'h05, 8'h04);
		rd(8'h03, 8'h03);
		wr(8'h04, 8'h03);
		rd(8'h05, 8'h00);
		rd(8'h03, 8'h00);
		wr(8'h00, 8'h0d);
		frm(16'h0000, 1'b0, 1'b1);
		frm(16'h0000, 1'b1, 1'b0);
		rd(8'h03, 8'h03);
		wr(8'h03, 8'hff);
		rd(8'h03, 8'h03);
		wr(8'h03, 8'hfe);
		rd(8'h03, 8'h02);
		wr_rd(8'h04, 8'h02, 8'h02);
		rd(8'h05, 8'h01);
		rd(8'h03, 8'h00);
		wr_rd(8'h04, 8'h01, 8'h01);
		rd(8'h05, 8'h00);
		rd(8'h04, 8'h00);
		wr(8'h06, 8'h11);
		rd(8'h06, 8'h2a);
		wr(8'h06, 8'h91);
		@(posedge i_sys_clk);
		i_gain_auto <= 7'h55;
		rd(8'h06, 8'h91);
		chk("gain", 16'h0011, {9'h0, o_gain_value});
		wr(8'h06, 8'h00);
		rd(8'h06, 8'h55);
		end_sim();
	end
endmodule
